// file: logic/erw_window.sv
`timescale 1ns/1ps
`include "erw_params.svh"

module erw_window (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               cold_rst,
	input  wire logic               awvalid,
	output logic                    awready,
	input  wire logic [7:0]         awaddr,
	input  wire logic               wvalid,
	output logic                    wready,
	input  wire logic [31:0]        wdata,
	input  wire logic [3:0]         wstrb,
	output logic                    bvalid,
	input  wire logic               bready,
	output logic [1:0]              bresp,
	input  wire logic               arvalid,
	output logic                    arready,
	input  wire logic [7:0]         araddr,
	output logic                    rvalid,
	input  wire logic               rready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	input  wire erw_pkg::erw_sreq_t sreq,
	output logic                    sreq_ready,
	output erw_pkg::erw_sresp_t     sresp,
	output erw_pkg::erw_rec_t       rec,
	input  wire logic [63:0]        rec0_rdata,
	input  wire logic [63:0]        rec1_rdata,
	output logic                    irq
);

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------

	// map a system-register encoding onto a window
	function automatic erw_pkg::erw_win_t win_decode(input erw_pkg::erw_sreq_t r);
		erw_pkg::erw_win_t w;
		w = erw_pkg::WIN_NONE;
		if (r.op0 == `ERW_ENC_PF_OP0 && r.op1 == `ERW_ENC_PF_OP1 &&
		    r.crn == `ERW_ENC_PF_CRN && r.crm == `ERW_ENC_PF_CRM) begin
			if (r.op2 == `ERW_ENC_CDN_OP2)
				w = erw_pkg::WIN_CDN;
			else if (r.op2 == `ERW_ENC_CTL_OP2)
				w = erw_pkg::WIN_CTL;
			else if (r.op2 == `ERW_ENC_FEAT_OP2)
				w = erw_pkg::WIN_FEAT;
		end else if (r.op0 == `ERW_ENC_MISC_OP0 && r.op1 == `ERW_ENC_MISC_OP1 &&
		             r.crn == `ERW_ENC_MISC_CRN && r.crm == `ERW_ENC_MISC_CRM) begin
			if (r.op2 == `ERW_ENC_MISC0_OP2)
				w = erw_pkg::WIN_MISC0;
			else if (r.op2 == `ERW_ENC_MISC1_OP2)
				w = erw_pkg::WIN_MISC1;
		end
		return w;
	endfunction : win_decode

	// merge a strobed bus write into a narrow register
	function automatic logic [31:0] strobe_merge(input logic [31:0] old_v,
	                                             input logic [31:0] new_v,
	                                             input logic [3:0]  strb);
		logic [31:0] v;
		v = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				v[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return v;
	endfunction : strobe_merge

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	erw_pkg::erw_state_t s_q;
	erw_pkg::erw_state_t s_d;

	erw_pkg::erw_win_t   win;
	logic                pf_win;
	logic                reach;
	logic                undef_c;
	logic                thyp_c;
	logic                tmon_c;
	logic                sel_eff;
	logic                sel_wr;
	logic [31:0]         wr_val;
	logic [31:0]         rd_val;
	logic                rd_hit;
	logic                wr_hit;
	logic [3:0]          events;

	// ------------------------------------------------------------------------
	// access decode and permission
	// ------------------------------------------------------------------------

	// permission never looks at the host-extension bit
	always_comb begin
		win     = win_decode(sreq);
		pf_win  = (win == erw_pkg::WIN_CDN) || (win == erw_pkg::WIN_CTL) || (win == erw_pkg::WIN_FEAT);
		reach   = 1'b0;
		undef_c = 1'b0;
		thyp_c  = 1'b0;
		tmon_c  = 1'b0;
		unique case (sreq.level)
			erw_pkg::LVL_USER: begin
				undef_c = 1'b1;
			end
			erw_pkg::LVL_KERNEL: begin
				reach = s_q.ctrl[`ERW_CTRL_AUXH] && s_q.ctrl[`ERW_CTRL_AUXM];
				// kernel level does not exist under general trapping in the non-secure state
				if (s_q.ctrl[`ERW_CTRL_NS] && s_q.ctrl[`ERW_CTRL_GTRAP])
					reach = 1'b0;
			end
			erw_pkg::LVL_HYP: begin
				reach = s_q.ctrl[`ERW_CTRL_AUXM] && s_q.ctrl[`ERW_CTRL_NS];
			end
			erw_pkg::LVL_MON: begin
				reach = 1'b1;
			end
		endcase
		if (win == erw_pkg::WIN_NONE)
			undef_c = 1'b1;
		else if (!pf_win)
			undef_c = undef_c; // misc windows: only user level refused
		else if (!reach)
			undef_c = 1'b1;
		if (win == erw_pkg::WIN_FEAT && sreq.write)
			undef_c = 1'b1;
		// the hypervisor trap outranks the monitor trap
		if (!undef_c && pf_win && sreq.level == erw_pkg::LVL_KERNEL &&
		    s_q.ctrl[`ERW_CTRL_NS] && s_q.ctrl[`ERW_CTRL_HTRAP])
			thyp_c = 1'b1;
		else if (!undef_c && pf_win && (sreq.level == erw_pkg::LVL_KERNEL ||
		         sreq.level == erw_pkg::LVL_HYP) && s_q.ctrl[`ERW_CTRL_MTRAP])
			tmon_c = 1'b1;
	end

	// a selector write landing this cycle already steers a window access taken now
	assign sel_wr  = s_q.aw_got && s_q.w_got && !s_q.bvalid && s_q.aw_addr == `ERW_OFS_SEL && s_q.w_strb[0];
	assign sel_eff = sel_wr ? s_q.w_data[`ERW_SEL_BIT] : s_q.sel;

	// ------------------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------------------
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (araddr)
			`ERW_OFS_SEL:    rd_val = {31'h0000_0000, s_q.sel};
			`ERW_OFS_CTRL:   rd_val = {25'h000_0000, s_q.ctrl};
			`ERW_OFS_STATUS: rd_val = {28'h000_0000, s_q.status};
			`ERW_OFS_MASK:   rd_val = {28'h000_0000, s_q.mask};
			`ERW_OFS_LAST:   rd_val = {24'h00_0000, s_q.last};
			default:         rd_hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		s_d    = s_q;
		events = 4'h0;
		wr_val = 32'h0000_0000;
		wr_hit = 1'b0;

		// bus write: address and data taken in either order
		if (awvalid && awready) begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			s_d.w_got  = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = `ERW_RESP_OKAY;
			unique case (s_q.aw_addr)
				`ERW_OFS_SEL: begin
					wr_val = strobe_merge({31'h0000_0000, s_q.sel}, s_q.w_data, s_q.w_strb);
					s_d.sel = wr_val[`ERW_SEL_BIT];
				end
				`ERW_OFS_CTRL: begin
					wr_val = strobe_merge({25'h000_0000, s_q.ctrl}, s_q.w_data, s_q.w_strb);
					s_d.ctrl = wr_val[6:0];
				end
				`ERW_OFS_STATUS: begin
					wr_val = strobe_merge(32'h0000_0000, s_q.w_data, s_q.w_strb);
					wr_hit = 1'b1;
				end
				`ERW_OFS_MASK: begin
					wr_val = strobe_merge({28'h000_0000, s_q.mask}, s_q.w_data, s_q.w_strb);
					s_d.mask = wr_val[3:0];
				end
				`ERW_OFS_LAST: s_d.bresp = `ERW_RESP_SLVERR;
				default:       s_d.bresp = `ERW_RESP_SLVERR;
			endcase
		end
		if (s_q.bvalid && bready)
			s_d.bvalid = 1'b0;

		// bus read
		if (arvalid && arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd_val;
			s_d.rresp  = rd_hit ? `ERW_RESP_OKAY : `ERW_RESP_SLVERR;
		end else if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end

		// window access sequencer
		unique case (s_q.fsm)
			erw_pkg::ST_IDLE: begin
				s_d.rec.valid  = 1'b0;
				s_d.resp.valid = 1'b0;
				if (sreq.valid) begin
					s_d.resp.undef    = undef_c;
					s_d.resp.trap_hyp = thyp_c;
					s_d.resp.trap_mon = tmon_c;
					s_d.resp.rdata    = 64'h0000_0000_0000_0000;
					s_d.last          = {sel_eff, sreq.write, win, undef_c, thyp_c, tmon_c};
					events[`ERW_EV_UNDEF]    = undef_c;
					events[`ERW_EV_TRAP_HYP] = thyp_c;
					events[`ERW_EV_TRAP_MON] = tmon_c;
					if (undef_c || thyp_c || tmon_c) begin
						s_d.resp.valid = 1'b1;
						s_d.fsm        = erw_pkg::ST_ANSWER;
					end else begin
						s_d.rec.valid = 1'b1;
						s_d.rec.bank  = sel_eff;
						s_d.rec.write = sreq.write;
						s_d.rec.idx   = win;
						s_d.rec.wdata = sreq.wdata;
						s_d.fsm       = erw_pkg::ST_ISSUE;
					end
				end
			end
			erw_pkg::ST_ISSUE: begin
				// record banks answer combinationally while the request stands
				s_d.rec.valid  = 1'b0;
				s_d.resp.valid = 1'b1;
				if (!s_q.rec.write)
					s_d.resp.rdata = s_q.rec.bank ? rec1_rdata : rec0_rdata;
				events[`ERW_EV_DONE] = 1'b1;
				s_d.fsm = erw_pkg::ST_ANSWER;
			end
			erw_pkg::ST_ANSWER: begin
				s_d.resp.valid = 1'b0;
				s_d.fsm        = erw_pkg::ST_IDLE;
			end
			default: begin
				s_d.fsm = erw_pkg::ST_IDLE;
			end
		endcase

		// sticky status: a new event wins over a write-one clear
		s_d.status = (s_q.status & ~(wr_hit ? wr_val[3:0] : 4'h0)) | events;

		// warm reset keeps the selector; only cold reset clears it
		if (rst || cold_rst) begin
			s_d        = '0;
			s_d.fsm    = erw_pkg::ST_IDLE;
			s_d.ctrl   = `ERW_RST_CTRL;
			s_d.mask   = `ERW_RST_MASK;
			s_d.sel    = cold_rst ? `ERW_RST_SEL : s_q.sel;
		end
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	// write ready terms stay low while a write waits for its answer, to keep one in flight
	assign awready    = !s_q.aw_got && !s_q.bvalid;
	assign wready     = !s_q.w_got && !s_q.bvalid;
	assign bvalid     = s_q.bvalid;
	assign bresp      = s_q.bresp;
	assign arready    = !s_q.rvalid;
	assign rvalid     = s_q.rvalid;
	assign rdata      = s_q.rdata;
	assign rresp      = s_q.rresp;
	assign sreq_ready = s_q.fsm == erw_pkg::ST_IDLE;
	assign sresp      = s_q.resp;
	assign rec        = s_q.rec;
	assign irq        = |(s_q.status & s_q.mask);

endmodule : erw_window

// file: common/erw_params.svh
`ifndef ERW_PARAMS_SVH
`define ERW_PARAMS_SVH

// ----------------------------------------------------------------------------
// register bus map (byte addresses)
// ----------------------------------------------------------------------------
`define ERW_OFS_SEL       8'h00
`define ERW_OFS_CTRL      8'h04
`define ERW_OFS_STATUS    8'h08
`define ERW_OFS_MASK      8'h0C
`define ERW_OFS_LAST      8'h10

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ERW_SEL_BIT       0
`define ERW_CTRL_AUXH     0
`define ERW_CTRL_AUXM     1
`define ERW_CTRL_HTRAP    2
`define ERW_CTRL_MTRAP    3
`define ERW_CTRL_GTRAP    4
`define ERW_CTRL_NS       5
`define ERW_CTRL_HEXT     6
`define ERW_EV_UNDEF      0
`define ERW_EV_TRAP_HYP   1
`define ERW_EV_TRAP_MON   2
`define ERW_EV_DONE       3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ERW_RST_SEL       1'h0
`define ERW_RST_CTRL      7'h00
`define ERW_RST_MASK      4'h0

// ----------------------------------------------------------------------------
// window encodings: op0, op1, crn, crm, op2
// ----------------------------------------------------------------------------
`define ERW_ENC_PF_OP0    2'h3
`define ERW_ENC_PF_OP1    3'h0
`define ERW_ENC_PF_CRN    4'hF
`define ERW_ENC_PF_CRM    4'h2
`define ERW_ENC_CDN_OP2   3'h2
`define ERW_ENC_CTL_OP2   3'h1
`define ERW_ENC_FEAT_OP2  3'h0
`define ERW_ENC_MISC_OP0  2'h3
`define ERW_ENC_MISC_OP1  3'h0
`define ERW_ENC_MISC_CRN  4'h5
`define ERW_ENC_MISC_CRM  4'h5
`define ERW_ENC_MISC0_OP2 3'h0
`define ERW_ENC_MISC1_OP2 3'h1

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define ERW_RESP_OKAY     2'h0
`define ERW_RESP_SLVERR   2'h2

`endif

// file: common/erw_pkg.sv
package erw_pkg;

	// ------------------------------------------------------------------------
	// privilege levels, windows and sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		LVL_USER   = 2'h0,
		LVL_KERNEL = 2'h1,
		LVL_HYP    = 2'h2,
		LVL_MON    = 2'h3
	} erw_level_t;

	typedef enum logic [2:0] {
		WIN_MISC0 = 3'h0,
		WIN_MISC1 = 3'h1,
		WIN_CDN   = 3'h2,
		WIN_CTL   = 3'h3,
		WIN_FEAT  = 3'h4,
		WIN_NONE  = 3'h7
	} erw_win_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_ISSUE  = 2'h1,
		ST_ANSWER = 2'h3
	} erw_fsm_t;

	// ------------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  op0;
		logic [2:0]  op1;
		logic [3:0]  crn;
		logic [3:0]  crm;
		logic [2:0]  op2;
		erw_level_t  level;
		logic [63:0] wdata;
	} erw_sreq_t;

	typedef struct packed {
		logic        valid;
		logic        undef;
		logic        trap_hyp;
		logic        trap_mon;
		logic [63:0] rdata;
	} erw_sresp_t;

	typedef struct packed {
		logic        valid;
		logic        bank;
		logic        write;
		erw_win_t    idx;
		logic [63:0] wdata;
	} erw_rec_t;

	typedef struct packed {
		erw_fsm_t    fsm;
		logic        sel;
		logic [6:0]  ctrl;
		logic [3:0]  status;
		logic [3:0]  mask;
		logic [7:0]  last;
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		erw_rec_t    rec;
		erw_sresp_t  resp;
	} erw_state_t;

endpackage : erw_pkg

// file: bench/erw_banks.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// error record banks: bank 0 core-local, bank 1 shared cluster
// ----------------------------------------------------------------------------
module erw_banks (
	input  wire logic              clk,
	input  wire erw_pkg::erw_rec_t rec,
	output logic [63:0]            rec0_rdata,
	output logic [63:0]            rec1_rdata
);
	logic [63:0] m0 [5];
	logic [63:0] m1 [5];
	logic [63:0] h0;
	logic [63:0] h1;
	wire         ok = rec.valid && (rec.idx < 3'h5);

	// known start so the read-only feature words can be predicted
	initial begin
		for (int i = 0; i < 5; i++) begin
			m0[i] = 64'h0A00 + 64'(i);
			m1[i] = 64'h0B00 + 64'(i);
		end
		h0 = '0;
		h1 = '0;
	end

	// read data only while asked; otherwise the inverse of the last word, so stale reads show
	assign rec0_rdata = ok ? m0[rec.idx] : ~h0;
	assign rec1_rdata = ok ? m1[rec.idx] : ~h1;

	// writes land on the edge that ends the request cycle
	always @(posedge clk) begin
		h0 <= rec0_rdata;
		h1 <= rec1_rdata;
		if (ok && rec.write && rec.bank) m1[rec.idx] <= rec.wdata;
		if (ok && rec.write && !rec.bank) m0[rec.idx] <= rec.wdata;
	end
endmodule : erw_banks

// file: bench/erw_window_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// sysreg window checker
// ----------------------------------------------------------------------------
module erw_window_chk (
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                cold_rst,
	input wire erw_pkg::erw_sreq_t  sreq,
	input wire logic                sreq_ready,
	input wire erw_pkg::erw_sresp_t sresp,
	input wire erw_pkg::erw_rec_t   rec,
	input wire logic [63:0]         rec0_rdata,
	input wire logic [63:0]         rec1_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || cold_rst);

	// decode helpers shared by the properties
	wire        take = sreq.valid && sreq_ready;
	wire        pf   = sreq.op0 == 2'h3 && sreq.op1 == 3'h0 && sreq.crn == 4'hF && sreq.crm == 4'h2;
	wire        misc = sreq.op0 == 2'h3 && sreq.op1 == 3'h0 && sreq.crn == 4'h5 && sreq.crm == 4'h5;
	wire        mon  = sreq.level == erw_pkg::LVL_MON;
	wire        usr  = sreq.level == erw_pkg::LVL_USER;
	wire [63:0] brd  = rec.bank ? rec1_rdata : rec0_rdata;

	property p_user_undef;
		take && (pf || misc) && usr |=> sresp.valid && sresp.undef && !rec.valid;
	endproperty
	property p_cdn_map;
		take && pf && mon && sreq.op2 == 3'h2 |=> rec.valid && rec.idx == erw_pkg::WIN_CDN && rec.write == $past(sreq.write);
	endproperty
	property p_ctl_map;
		take && pf && mon && sreq.op2 == 3'h1 |=> rec.valid && rec.idx == erw_pkg::WIN_CTL && rec.write == $past(sreq.write);
	endproperty
	property p_feat_rd;
		take && pf && mon && sreq.op2 == 3'h0 && !sreq.write |=> rec.valid && rec.idx == erw_pkg::WIN_FEAT && !rec.write;
	endproperty
	property p_feat_wr;
		take && pf && sreq.op2 == 3'h0 && sreq.write |=> sresp.valid && sresp.undef && !rec.valid;
	endproperty
	property p_misc0;
		take && misc && !usr && sreq.op2 == 3'h0 |=> rec.valid && rec.idx == erw_pkg::WIN_MISC0;
	endproperty
	property p_misc1;
		take && misc && !usr && sreq.op2 == 3'h1 |=> rec.valid && rec.idx == erw_pkg::WIN_MISC1;
	endproperty
	property p_rdata;
		rec.valid && !rec.write |=> sresp.valid && !sresp.undef && sresp.rdata == $past(brd);
	endproperty

	a_user_undef: assert property (p_user_undef) else $error("user access not undefined");
	a_cdn_map: assert property (p_cdn_map) else $error("countdown window misrouted");
	a_ctl_map: assert property (p_ctl_map) else $error("control window misrouted");
	a_feat_rd: assert property (p_feat_rd) else $error("feature window misrouted");
	a_feat_wr: assert property (p_feat_wr) else $error("feature write accepted");
	a_misc0: assert property (p_misc0) else $error("misc0 window misrouted");
	a_misc1: assert property (p_misc1) else $error("misc1 window misrouted");
	a_rdata: assert property (p_rdata) else $error("read data not from addressed bank");

	c_bank1: cover property (rec.valid && rec.bank);
	c_trap_hyp: cover property (sresp.valid && sresp.trap_hyp);
	c_trap_mon: cover property (sresp.valid && sresp.trap_mon);
endmodule : erw_window_chk

bind erw_window erw_window_chk u_chk (.*);

// file: bench/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// window bench
// ----------------------------------------------------------------------------
module tb;
	logic                clk, rst, cold_rst, awvalid, wvalid, bready, arvalid, rready;
	logic                awready, wready, bvalid, arready, rvalid, sreq_ready, irq;
	logic [7:0]          awaddr, araddr;
	logic [31:0]         wdata, rdata;
	logic [3:0]          wstrb;
	logic [1:0]          bresp, rresp;
	logic [63:0]         rec0_rdata, rec1_rdata;
	erw_pkg::erw_sreq_t  sreq;
	erw_pkg::erw_sresp_t sresp, rs;
	erw_pkg::erw_rec_t   rec;
	int                  err_total, checks_done;
	// {ctrl, level, undef/trap_hyp/trap_mon}
	localparam logic [11:0] TBL [13] = '{12'h004, 12'h00C, 12'h018, 12'h468, 12'h450, 12'h054, 12'h4EA,
	                                     12'h0E8, 12'h571, 12'h66C, 12'hC68, 12'h178, 12'h5EA};

	erw_window dut (.*);
	erw_banks  banks (.*);

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// bus write: address and data offered together, each dropped once taken; only the watchdog ends a wait
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(64'(bresp), 64'(er));
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(64'(rresp), 64'(er));
		if (er == 2'h0) chk(64'(rdata), 64'(d));
	endtask : axr

	// one window access; the answer lands in rs
	task automatic sr(input logic w, input logic m, input logic [2:0] o2, input logic [1:0] l, input logic [63:0] d);
		@(posedge clk);
		sreq <= '{1'b1, w, 2'h3, 3'h0, m ? 4'h5 : 4'hF, m ? 4'h5 : 4'h2, o2, erw_pkg::erw_level_t'(l), d};
		do begin
			@(posedge clk);
		end while (sreq_ready !== 1'b1);
		sreq.valid <= 1'b0;
		do begin
			@(posedge clk);
		end while (sresp.valid !== 1'b1);
		rs = sresp;
	endtask : sr

	task automatic t_regs;
		for (int a = 0; a < 20; a += 4) axr(8'(a), 32'h0, 2'h0);
		axr(8'h14, 32'h0, 2'h2);
		axw(8'h10, 32'h0, 2'h2);
		axw(8'h20, 32'h0, 2'h2);
	endtask : t_regs

	// every window in both banks, then a selector flip read straight after
	task automatic t_route;
		for (int b = 0; b < 2; b++) begin
			axw(8'h00, 32'(b), 2'h0);
			for (int i = 0; i < 4; i++) sr(1'b1, i < 2, 3'((i == 2) ? 2 : (i != 0)), 2'h3, 64'h5A00 + 64'(16 * b + i));
			for (int i = 0; i < 4; i++) begin
				sr(1'b0, i < 2, 3'((i == 2) ? 2 : (i != 0)), 2'h3, 64'h0);
				chk(rs.rdata, 64'h5A00 + 64'(16 * b + i));
			end
			sr(1'b0, 1'b0, 3'h0, 2'h3, 64'h0);
			chk(rs.rdata, 64'h0A04 + 64'(256 * b));
		end
		axw(8'h00, 32'h0, 2'h0);
		sr(1'b0, 1'b0, 3'h2, 2'h3, 64'h0);
		chk(rs.rdata, 64'h5A02);
		sr(1'b1, 1'b0, 3'h0, 2'h3, 64'h0);
		chk(64'(rs.undef), 64'h1);
		// last-access record: selector 0, write, feature window, undefined
		axr(8'h10, 32'h64, 2'h0);
	endtask : t_route

	task automatic t_perm;
		for (int i = 0; i < 13; i++) begin
			axw(8'h04, 32'(TBL[i][11:5]), 2'h0);
			sr(1'b0, 1'b0, 3'h2, TBL[i][4:3], 64'h0);
			chk(64'({rs.undef, rs.trap_hyp, rs.trap_mon}), 64'(TBL[i][2:0]));
		end
	endtask : t_perm

	// events are sticky; mask gates the level output
	task automatic t_irq;
		axr(8'h08, 32'hF, 2'h0);
		chk(64'(irq), 64'h0);
		axw(8'h0C, 32'h1, 2'h0);
		@(posedge clk);
		chk(64'(irq), 64'h1);
		axw(8'h08, 32'h1, 2'h0);
		@(posedge clk);
		chk(64'(irq), 64'h0);
		axr(8'h08, 32'hE, 2'h0);
		axw(8'h08, 32'hF, 2'h0);
		axw(8'h0C, 32'h0, 2'h0);
	endtask : t_irq

	task automatic t_warm;
		axw(8'h00, 32'h1, 2'h0);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		axr(8'h00, 32'h1, 2'h0);
		axr(8'h04, 32'h0, 2'h0);
		@(posedge clk);
		cold_rst <= 1'b1;
		@(posedge clk);
		cold_rst <= 1'b0;
		axr(8'h00, 32'h0, 2'h0);
	endtask : t_warm

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	// main sequence; both resets together at start
	initial begin
		err_total = 0;
		checks_done = 0;
		{rst, cold_rst} = 2'b11;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		sreq = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		cold_rst <= 1'b0;
		t_regs;
		t_route;
		t_perm;
		t_irq;
		t_warm;
		give_verdict;
	end

	// hang guard, well past the few hundred cycles the run needs
	initial begin
		#(25 * 20000);
		err_total++;
		give_verdict;
	end
endmodule : tb
